// ===== logic/eddr_pkg.sv
`default_nettype none
// shared constants and types of the two-word burst memory port
package eddr_pkg;
   // organisation codes
   localparam logic [1:0] ORG_X8 = 2'h0; // 8-bit words
   localparam logic [1:0] ORG_X18 = 2'h1; // 18-bit words
   localparam logic [1:0] ORG_X36 = 2'h2; // 36-bit words
   // pin widths
   localparam int ADDR_PINS = 20; // external address inputs
   localparam int MAX_LANES = 4; // byte select inputs
   localparam int MAX_DW = 36; // widest data bus
   localparam int BURST_LEN = 2; // words per burst, the only length
   localparam int ADDR_MSB = 19; // top address input, unused in x36
   localparam int ADDR_LSB = 0; // burst start bit position
   // storage window held in flip-flops
   localparam int MEM_IW = 6; // index width of the model array
   localparam int MEM_DEPTH = 64; // entries, two to MEM_IW
   // clock pins packed as one vector
   localparam int CK_IN = 0; // in_clk position
   localparam int CK_IN_N = 1; // in_clk_n position
   localparam int CK_OUT = 2; // out_clk position
   localparam int CK_OUT_N = 3; // out_clk_n position
   localparam int CK_MODE = 4; // single clock strap position
   localparam int CK_W = 5; // vector width
   // data width per organisation
   function automatic int eddr_dw(input logic [1:0] org);
      eddr_dw = (org == ORG_X8) ? 8 : (org == ORG_X18) ? 18 : 36;
   endfunction
   // lane width per organisation
   function automatic int eddr_lw(input logic [1:0] org);
      eddr_lw = (org == ORG_X8) ? 4 : 9;
   endfunction
   // lane count per organisation
   function automatic int eddr_nl(input logic [1:0] org);
      eddr_nl = (org == ORG_X36) ? 4 : 2;
   endfunction
   // synchronous pin group, sampled together
   typedef struct packed {
      logic load_n; // new transaction strobe, low active
      logic rd_wr_sel; // high read, low write
      logic [ADDR_PINS-1:0] addr; // shared address
      logic [MAX_LANES-1:0] lane_n; // byte lane selects, low active
      logic [MAX_DW-1:0] data; // write data
   } eddr_pins_t;
   // write side states
   typedef enum logic [1:0] {
      WR_IDLE = 2'h0,
      WR_W0 = 2'h1,
      WR_W1 = 2'h3
   } eddr_wr_t;
   // read side states, gray except the return from RD_HOLD to RD_IDLE
   typedef enum logic [1:0] {
      RD_IDLE = 2'h0,
      RD_W1 = 2'h1,
      RD_HOLD = 2'h3
   } eddr_rd_t;
endpackage
`default_nettype wire

// ===== logic/eddr_lane_merge.sv
`timescale 1ns/1ps
`default_nettype none
// merges a new word into the stored one, lane by lane
module eddr_lane_merge #(
   parameter int DW = 36, // word width
   parameter int LW = 9, // lane width
   parameter int NL = 4 // lane count
) (
   input wire logic [DW-1:0] old_word, // stored contents
   input wire logic [DW-1:0] new_word, // incoming data
   input wire logic [NL-1:0] lane_sel_n, // low selects a lane
   output logic [DW-1:0] merged // word to store
);
   // one mux per lane
   for (genvar l = 0; l < NL; l++) begin : g_lane
      // deselected lane keeps old byte
      assign merged[l*LW +: LW] = lane_sel_n[l] ? old_word[l*LW +: LW]
                                                : new_word[l*LW +: LW]; // see RULE8 RULE9
   end
endmodule // eddr_lane_merge
`default_nettype wire

// ===== logic/eddr_port.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: write data taken on both input clock edges
// RULE2: read words on output clocks, else input clocks
// RULE3: data drivers off when no read
// RULE4: controller pulls load_n low with address, direction
// RULE5: every access moves exactly two words
// RULE6: byte selects low active, sampled during writes
// RULE7: byte select sampled with its data word
// RULE8: lane to bit mapping per organisation
// RULE9: deselected byte keeps stored value
// RULE10: data bus 8, 18 or 36 bits
// RULE11: one address bus for reads and writes
// RULE12: x8 burst always starts at word zero
// RULE13: start bit loads counter, then advances linearly
// RULE14: x18 twenty address inputs, x36 nineteen
// RULE15: address ignored unless access selected
// RULE16: rd_wr_sel high read, low write
// RULE17: accesses begin only on in_clk rise
// RULE18: second word toggles low address bit
module eddr_port
   import eddr_pkg::*;
#(
   parameter logic [1:0] ORG = ORG_X36, // organisation
   parameter int DW = eddr_dw(ORG), // data width, see RULE10
   parameter int LW = eddr_lw(ORG), // lane width
   parameter int NL = eddr_nl(ORG) // lane count
) (
   input wire logic mclk, // system clock
   input wire logic rst, // async reset, high
   input wire logic in_clk, // input clock pin
   input wire logic in_clk_n, // complementary input clock pin
   input wire logic out_clk, // output clock pin
   input wire logic out_clk_n, // complementary output clock pin
   input wire logic single_clk_mode, // high: reads follow input clocks
   input wire logic load_n, // transaction strobe, low active
   input wire logic rd_wr_sel, // high read, low write
   input wire logic [ADDR_PINS-1:0] addr, // shared address pins
   input wire logic [MAX_LANES-1:0] byte_lane_sel_n, // lane selects
   input wire logic [DW-1:0] data_pins_i, // data pins, input side
   output logic [DW-1:0] data_pins_o, // data pins, output side
   output logic data_pins_oe // high while driving data pins
);

   // address bits that take part, see RULE14
   localparam logic [ADDR_PINS-1:0] ADDR_ONES = '1;
   localparam logic [ADDR_PINS-1:0] ADDR_MASK =
      (ORG == ORG_X36) ? (ADDR_ONES >> 1) : ADDR_ONES;

   // word index of a burst beat, see RULE12 RULE13 RULE18
   function automatic logic [MEM_IW-1:0] beat_idx(
      input logic [ADDR_PINS-1:0] a,
      input logic cnt
   );
      if (ORG == ORG_X8) begin
         // lsb forced to zero, counter supplies the beat
         beat_idx = {a[MEM_IW-2:0], cnt}; // see RULE12
      end else begin
         // counter loaded with start bit, toggled for beat two
         beat_idx = {a[MEM_IW-1:1], a[ADDR_LSB] ^ cnt}; // see RULE13 RULE18
      end
   endfunction

   // pin sync stages
   eddr_pins_t pin_s1_ff; // first stage, read only by second
   eddr_pins_t pin_s2_ff; // second stage, used by logic
   eddr_pins_t pin_raw; // pins gathered
   logic [CK_W-1:0] ck_s1_ff; // clock pins, first stage
   logic [CK_W-1:0] ck_s2_ff; // clock pins, second stage
   logic [CK_W-1:0] ck_s3_ff; // delayed copy for edges
   logic [CK_W-1:0] ck_rise; // rising edge pulses
   // decoded events
   logic load_ev; // transaction loaded at in_clk rise
   logic rd_load; // read loaded
   logic wr_load; // write loaded
   logic rd_rise0; // edge that drives first read word
   logic rd_rise1; // edge that drives second read word
   // write side
   eddr_wr_t wr_st_ff; // write state
   eddr_wr_t nxt_wr_st; // next write state
   logic [ADDR_PINS-1:0] wr_addr_ff; // captured write address
   logic wr_commit; // store one beat this cycle
   logic [MEM_IW-1:0] wr_idx; // target of the beat
   logic [DW-1:0] wr_merged; // merged word
   // read side
   eddr_rd_t rd_st_ff; // read state
   eddr_rd_t nxt_rd_st; // next read state
   logic rd_pend_ff; // read waiting for its first edge
   logic [ADDR_PINS-1:0] rd_pend_addr_ff; // its address
   logic [ADDR_PINS-1:0] rd_act_addr_ff; // burst being driven
   logic rd_take; // first word goes out now
   logic rd_beat1; // second word goes out now
   logic rd_stop; // drivers released now
   // storage
   logic [DW-1:0] mem_ff [MEM_DEPTH]; // array in flip-flops

   // gather the synchronous pins
   always_comb begin
      pin_raw = '0;
      pin_raw.load_n = load_n;
      pin_raw.rd_wr_sel = rd_wr_sel;
      pin_raw.addr = addr;
      pin_raw.lane_n[NL-1:0] = byte_lane_sel_n[NL-1:0];
      pin_raw.data[DW-1:0] = data_pins_i;
   end

   // two stage sync of the data and control pins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_s1_ff <= '{load_n: 1'b1, default: '0};
         pin_s2_ff <= '{load_n: 1'b1, default: '0};
      end else begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // two stage sync of clock pins plus edge history
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ck_s1_ff <= '0;
         ck_s2_ff <= '0;
         ck_s3_ff <= '0;
      end else begin
         ck_s1_ff <= {single_clk_mode, out_clk_n, out_clk, in_clk_n, in_clk};
         ck_s2_ff <= ck_s1_ff;
         ck_s3_ff <= ck_s2_ff;
      end
   end

   // edge detect on settled stages only
   assign ck_rise = ck_s2_ff & ~ck_s3_ff;

   // access start only at in_clk rise, see RULE17 RULE4
   assign load_ev = ck_rise[CK_IN] & ~pin_s2_ff.load_n;
   // direction decode, see RULE16 RULE11
   assign rd_load = load_ev & pin_s2_ff.rd_wr_sel;
   assign wr_load = load_ev & ~pin_s2_ff.rd_wr_sel;

   // read edges follow output or input clocks, see RULE2
   assign rd_rise0 = ck_s2_ff[CK_MODE] ? ck_rise[CK_IN] : ck_rise[CK_OUT];
   assign rd_rise1 = ck_s2_ff[CK_MODE] ? ck_rise[CK_IN_N] : ck_rise[CK_OUT_N];

   // write sequencing: two beats per burst, see RULE5 RULE1
   always_comb begin
      nxt_wr_st = wr_st_ff;
      wr_commit = 1'b0;
      wr_idx = beat_idx(wr_addr_ff, 1'b0);
      case (wr_st_ff)
         WR_IDLE: begin
            // wait for a write load
            if (wr_load) begin
               nxt_wr_st = WR_W0;
            end
         end
         WR_W0: begin
            // first word on in_clk_n rise
            if (ck_rise[CK_IN_N]) begin
               wr_commit = 1'b1; // see RULE1
               nxt_wr_st = WR_W1;
            end
         end
         WR_W1: begin
            // second word on next in_clk rise
            wr_idx = beat_idx(wr_addr_ff, 1'b1); // see RULE18
            if (ck_rise[CK_IN]) begin
               wr_commit = 1'b1; // see RULE1 RULE5
               nxt_wr_st = wr_load ? WR_W0 : WR_IDLE;
            end
         end
         default: begin
            // unknown code returns to idle
            nxt_wr_st = WR_IDLE;
         end
      endcase
   end

   // write state register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_st_ff <= WR_IDLE;
      end else begin
         wr_st_ff <= nxt_wr_st;
      end
   end

   // write address captured only on a load, see RULE15 RULE14
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_addr_ff <= '0;
      end else if (wr_load) begin
         wr_addr_ff <= pin_s2_ff.addr & ADDR_MASK;
      end
   end

   // lane merge against stored word, see RULE6 RULE7
   eddr_lane_merge #(
      .DW(DW),
      .LW(LW),
      .NL(NL)
   ) u_merge (
      .old_word(mem_ff[wr_idx]),
      .new_word(pin_s2_ff.data[DW-1:0]),
      .lane_sel_n(pin_s2_ff.lane_n[NL-1:0]),
      .merged(wr_merged)
   );

   // array update, selects sampled with the same beat, see RULE7 RULE9
   always_ff @(posedge mclk) begin
      if (wr_commit) begin
         mem_ff[wr_idx] <= wr_merged;
      end
   end

   // read sequencing
   always_comb begin
      nxt_rd_st = rd_st_ff;
      rd_take = 1'b0;
      rd_beat1 = 1'b0;
      rd_stop = 1'b0;
      case (rd_st_ff)
         RD_IDLE: begin
            // first word at next read edge
            if (rd_rise0 && rd_pend_ff) begin
               rd_take = 1'b1;
               nxt_rd_st = RD_W1;
            end
         end
         RD_W1: begin
            // second word at complementary edge, see RULE5
            if (rd_rise1) begin
               rd_beat1 = 1'b1;
               nxt_rd_st = RD_HOLD;
            end
         end
         RD_HOLD: begin
            // next burst follows, or drivers go off
            if (rd_rise0) begin
               if (rd_pend_ff) begin
                  rd_take = 1'b1;
                  nxt_rd_st = RD_W1;
               end else begin
                  rd_stop = 1'b1; // see RULE3
                  nxt_rd_st = RD_IDLE;
               end
            end
         end
         default: begin
            // unknown code returns to idle
            nxt_rd_st = RD_IDLE;
         end
      endcase
   end

   // read state register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_st_ff <= RD_IDLE;
      end else begin
         rd_st_ff <= nxt_rd_st;
      end
   end

   // pending read: new load wins over the take
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_pend_ff <= 1'b0;
         rd_pend_addr_ff <= '0;
      end else if (rd_load) begin
         rd_pend_ff <= 1'b1;
         rd_pend_addr_ff <= pin_s2_ff.addr & ADDR_MASK; // see RULE15 RULE14
      end else if (rd_take) begin
         rd_pend_ff <= 1'b0;
      end
   end

   // address of the burst on the pins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_act_addr_ff <= '0;
      end else if (rd_take) begin
         rd_act_addr_ff <= rd_pend_addr_ff;
      end
   end

   // output data register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_pins_o <= '0;
      end else if (rd_take) begin
         data_pins_o <= mem_ff[beat_idx(rd_pend_addr_ff, 1'b0)]; // see RULE2
      end else if (rd_beat1) begin
         data_pins_o <= mem_ff[beat_idx(rd_act_addr_ff, 1'b1)]; // see RULE2 RULE18
      end
   end

   // output enable, off whenever no read is on the pins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_pins_oe <= 1'b0;
      end else if (rd_take) begin
         data_pins_oe <= 1'b1;
      end else if (rd_stop) begin
         data_pins_oe <= 1'b0; // see RULE3
      end
   end

endmodule // eddr_port
`default_nettype wire

// ===== bench/eddr_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
// read-side pin timing checks of the burst port
module eddr_port_properties
   import eddr_pkg::*;
#(
   parameter int DW = 36 // data width
) (
   input wire logic mclk, // system clock
   input wire logic rst, // async reset, high
   input wire logic in_clk, // input clock pin
   input wire logic in_clk_n, // complementary input clock pin
   input wire logic out_clk, // output clock pin
   input wire logic out_clk_n, // complementary output clock pin
   input wire logic single_clk_mode, // reads follow input clocks
   input wire logic [DW-1:0] data_pins_o, // read data
   input wire logic data_pins_oe // driver enable
);
   logic [3:0] p_sh_ff; // first read pin history
   logic [3:0] n_sh_ff; // second read pin history
   logic [3:0] o_sh_ff; // output clock pin history
   logic ev_p; // first read pin rise, due at the pins now
   logic ev_n; // second read pin rise, due now
   logic ev_o; // output clock rise, due now
   // history resets like the design's pin stages
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         p_sh_ff <= '0;
         n_sh_ff <= '0;
         o_sh_ff <= '0;
      end else begin
         p_sh_ff <= {p_sh_ff[2:0], single_clk_mode ? in_clk : out_clk};
         n_sh_ff <= {n_sh_ff[2:0], single_clk_mode ? in_clk_n : out_clk_n};
         o_sh_ff <= {o_sh_ff[2:0], out_clk};
      end
   end
   // three edges from pin rise to output change
   assign ev_p = p_sh_ff[2] & ~p_sh_ff[3];
   assign ev_n = n_sh_ff[2] & ~n_sh_ff[3];
   assign ev_o = o_sh_ff[2] & ~o_sh_ff[3];
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // first word of a burst from idle goes out, enable rising
   sequence word0_s;
      $rose(data_pins_oe);
   endsequence
   reset_quiet_a: assert property ($fell(rst) |-> !data_pins_oe && data_pins_o == '0)
      else $error("pins driven after reset");
   oe_hold_a: assert property (!ev_p |-> $stable(data_pins_oe))
      else $error("enable moved without a read edge");
   word_hold_a: assert property (!(ev_p || ev_n) |-> $stable(data_pins_o))
      else $error("read data moved without a read edge");
   oe_rise_a: assert property (word0_s |-> ev_p)
      else $error("enable rose off the first read edge");
   oe_fall_a: assert property ($fell(data_pins_oe) |-> ev_p)
      else $error("enable fell off the first read edge");
   burst_min_a: assert property (word0_s |-> data_pins_oe [*6])
      else $error("burst shorter than two words");
   n_keeps_a: assert property (ev_n && $past(data_pins_oe) |-> data_pins_oe)
      else $error("second word edge ended the burst");
   single_ign_a: assert property (single_clk_mode && ev_o && !ev_p && !ev_n |->
      $stable(data_pins_o) && $stable(data_pins_oe))
      else $error("output clock acted in single clock mode");
endmodule // eddr_port_properties
bind eddr_port eddr_port_properties #(.DW(DW)) u_props (.mclk(mclk), .rst(rst),
   .in_clk(in_clk), .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n),
   .single_clk_mode(single_clk_mode), .data_pins_o(data_pins_o),
   .data_pins_oe(data_pins_oe));
`default_nettype wire

// ===== bench/eddr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory controller model: clock pins, strobe, address, lanes, data
module eddr_ctl_model
   import eddr_pkg::*;
(
   input wire logic mclk, // system clock
   output logic [3:0] ck, // in_clk, in_clk_n, out_clk, out_clk_n
   output var eddr_pins_t pins, // synchronous pin group
   output logic chk // high while a read edge expects a result
);
   // idle pins, all clocks low
   initial begin
      ck = '0;
      chk = 1'b0;
      pins = '0;
      pins.load_n = 1'b1;
   end
   // wait n edges, then step just past the edge
   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // one clock pin period, each level four edges long
   task automatic pulse(input int k, input logic c);
      ck[k] = 1'b1;
      chk = c;
      hold(4);
      ck[k] = 1'b0;
      chk = 1'b0;
      hold(4);
   endtask
   // one whole two-word transaction
   task automatic xfer(input logic rd, input logic [19:0] a, input logic [35:0] d0,
      input logic [35:0] d1, input logic [3:0] l0, input logic [3:0] l1, input logic sgl);
      pins.load_n = 1'b0;
      pins.rd_wr_sel = rd;
      pins.addr = a;
      hold(1);
      pulse(CK_IN, 1'b0);
      pins.load_n = 1'b1;
      pins.addr = ~a;
      pins.rd_wr_sel = ~rd;
      if (!rd) begin
         pins.data = d0;
         pins.lane_n = l0;
         hold(1);
         pulse(CK_IN_N, 1'b0);
         pins.data = d1;
         pins.lane_n = l1;
         hold(1);
         pulse(CK_IN, 1'b0);
         pins.data = ~d1; // released lines show garbage
         pins.lane_n = ~l1;
      end else begin
         if (sgl) pulse(CK_OUT, 1'b0);
         pulse(sgl ? CK_IN : CK_OUT, 1'b1);
         pulse(sgl ? CK_IN_N : CK_OUT_N, 1'b1);
         pulse(sgl ? CK_IN : CK_OUT, 1'b1);
      end
   endtask
endmodule // eddr_ctl_model
`default_nettype wire

// ===== bench/eddr_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
// self-checking bench of the burst port, widest and narrowest organisations side by side
module eddr_port_tb
   import eddr_pkg::*;
;
   logic mclk = 1'b0; // system clock
   logic rst = 1'b1; // reset
   logic single = 1'b0; // single clock strap
   logic [3:0] ck; // clock pins
   eddr_pins_t pins; // controller pin group
   logic chk; // read edge marker
   logic [35:0] q; // read data
   logic oe; // driver enable
   logic [35:0] mem [64]; // expected array
   logic [36:0] expq [$]; // expected enable and word per read edge
   logic [36:0] e_v; // oldest note
   int fails = 0; // mismatches
   int samples_checked = 0; // comparisons
   integer seed = 42994; // random seed
   logic [19:0] a_v; // random address
   logic [3:0] l_v; // random lanes
   logic [7:0] q8; // narrow read data
   logic oe8; // narrow driver enable
   logic [7:0] mem8 [64]; // expected narrow array
   logic [8:0] expq8 [$]; // narrow enable and word per read edge
   logic [8:0] e8_v; // oldest narrow note
   always #2.5 mclk = ~mclk;
   eddr_ctl_model u_ctl (.mclk(mclk), .ck(ck), .pins(pins), .chk(chk));
   eddr_port u_dut (.mclk(mclk), .rst(rst), .in_clk(ck[CK_IN]), .in_clk_n(ck[CK_IN_N]),
      .out_clk(ck[CK_OUT]), .out_clk_n(ck[CK_OUT_N]), .single_clk_mode(single),
      .load_n(pins.load_n), .rd_wr_sel(pins.rd_wr_sel), .addr(pins.addr),
      .byte_lane_sel_n(pins.lane_n), .data_pins_i(pins.data), .data_pins_o(q),
      .data_pins_oe(oe));
   // narrow organisation on the same pins, low lanes and data bits only
   eddr_port #(.ORG(ORG_X8)) u_dut8 (.mclk(mclk), .rst(rst), .in_clk(ck[CK_IN]),
      .in_clk_n(ck[CK_IN_N]), .out_clk(ck[CK_OUT]), .out_clk_n(ck[CK_OUT_N]),
      .single_clk_mode(single), .load_n(pins.load_n), .rd_wr_sel(pins.rd_wr_sel),
      .addr(pins.addr), .byte_lane_sel_n(pins.lane_n), .data_pins_i(pins.data[7:0]),
      .data_pins_o(q8), .data_pins_oe(oe8));
   // word index of a burst beat, top address bit unused
   function automatic int idx(input logic [19:0] a, input logic c);
      return int'({a[5:1], a[0] ^ c});
   endfunction
   // narrow beat index, burst always starts at word zero
   function automatic int idx8(input logic [19:0] a, input logic c);
      return int'({a[4:0], c});
   endfunction
   // lane-wise update of the narrow expected array, two four-bit lanes
   task automatic merge8(input int i, input logic [7:0] d, input logic [3:0] l);
      for (int k = 0; k < 2; k++) begin
         if (!l[k]) mem8[i][k*4+:4] = d[k*4+:4];
      end
   endtask
   function automatic logic [35:0] rnd();
      return 36'({$random(seed), $random(seed)});
   endfunction
   // lane-wise update of the expected array
   task automatic merge(input int i, input logic [35:0] d, input logic [3:0] l);
      for (int k = 0; k < 4; k++) begin
         if (!l[k]) mem[i][k*9+:9] = d[k*9+:9];
      end
   endtask
   task automatic wr(input logic [19:0] a, input logic [35:0] d0, input logic [35:0] d1,
      input logic [3:0] l0, input logic [3:0] l1);
      merge(idx(a, 1'b0), d0, l0);
      merge(idx(a, 1'b1), d1, l1);
      merge8(idx8(a, 1'b0), d0[7:0], l0);
      merge8(idx8(a, 1'b1), d1[7:0], l1);
      u_ctl.xfer(1'b0, a, d0, d1, l0, l1, 1'b0);
   endtask
   task automatic rd(input logic [19:0] a, input logic s);
      single = s;
      expq.push_back({1'b1, mem[idx(a, 1'b0)]});
      expq.push_back({1'b1, mem[idx(a, 1'b1)]});
      expq.push_back(37'h0);
      expq8.push_back({1'b1, mem8[idx8(a, 1'b0)]});
      expq8.push_back({1'b1, mem8[idx8(a, 1'b1)]});
      expq8.push_back(9'h0);
      u_ctl.xfer(1'b1, a, 36'h0, 36'h0, 4'h0, 4'h0, s);
      single = 1'b0;
   endtask
   // results are due three edges after each marked read edge
   always begin
      @(posedge chk);
      repeat (3) @(posedge mclk);
      #1;
      e_v = expq.pop_front();
      e8_v = expq8.pop_front();
      `CHK({oe, oe ? q : 36'h0}, e_v)
      `CHK({oe8, oe8 ? q8 : 8'h0}, e8_v)
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      stop_test();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge mclk);
      #1;
      rst = 1'b0;
      u_ctl.hold(2);
      for (int i = 0; i < 64; i++) wr(20'(i), rnd(), rnd(), 4'h0, 4'h0);
      for (int i = 0; i < 64; i++) rd(20'(i) | (20'(i & 1) << 19), 1'b0);
      $display("test fill and read done");
      for (int k = 0; k < 16; k++) begin
         wr(20'(k * 3), rnd(), rnd(), 4'(k), ~4'(k));
         rd(20'(k * 3), 1'b0);
      end
      $display("test byte lanes done");
      for (int k = 0; k < 16; k++) begin
         a_v = 20'($random(seed));
         l_v = 4'($random(seed));
         wr(a_v, rnd(), rnd(), l_v, ~l_v);
         rd(a_v ^ 20'h8_0000, 1'($random(seed)));
      end
      $display("test random mixed done");
      u_ctl.hold(8);
      stop_test();
   end
endmodule // eddr_port_tb
`default_nettype wire
